// [include/pic_pkg.sv]
// Constants, register map and helper functions of the interrupt controller
package pic_pkg;

  // ---------------------------------------------------------------------------
  // Source levels
  // ---------------------------------------------------------------------------
  localparam int NUM_LEVELS = 16;
  localparam int LVL_W      = 4;
  localparam int LVL_SW     = 1;
  localparam int LVL_WDT    = 2;
  localparam int LVL_EXT0   = 3;
  localparam int LVL_MASK0  = 4;

  // ---------------------------------------------------------------------------
  // Register map: word indices, byte address is index times four
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  IDX_ENABLE    = 8'h3A;
  localparam logic [7:0]  IDX_PENDING   = 8'h3C;
  localparam logic [7:0]  IDX_CONTROL   = 8'h3E;
  localparam logic [7:0]  ADR_ENABLE    = {IDX_ENABLE[5:0], 2'b00};
  localparam logic [7:0]  ADR_PENDING   = {IDX_PENDING[5:0], 2'b00};
  localparam logic [7:0]  ADR_CONTROL   = {IDX_CONTROL[5:0], 2'b00};
  localparam int          MASTER_BIT    = 0;
  localparam int          PIN_EN_BIT    = 0;
  localparam logic [15:0] ENABLE_RESET  = 16'h0000;
  localparam logic [15:0] PENDING_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_MASK   = 16'hFFF1;
  localparam logic [15:0] LATCH_MASK    = 16'hFFFC;
  localparam logic [15:0] CONTROL_MASK  = 16'h0001;

  // ---------------------------------------------------------------------------
  // Vectors and timing
  // ---------------------------------------------------------------------------
  localparam logic [15:0] VEC_BASE        = 16'hFFFE;
  localparam int          CLK_HZ          = 10_000_000;
  localparam int          ACCEPT_MCYCLES  = 8;
  localparam int          CLKS_PER_MCYCLE = 1;
  localparam int          ACCEPT_CYCLES   = ACCEPT_MCYCLES * CLKS_PER_MCYCLE;

  // Vector slot of a level, two bytes per level below the top
  function automatic logic [15:0] pic_vector(input logic [LVL_W-1:0] level);
    pic_vector = VEC_BASE - {11'h000, level, 1'b0};
  endfunction

  // One-hot mask of a level
  function automatic logic [15:0] pic_onehot(input logic [LVL_W-1:0] level);
    pic_onehot = 16'h0001 << level;
  endfunction

  // Byte-lane merge of a 16-bit register write
  function automatic logic [15:0] pic_merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                            input logic [1:0] sel);
    pic_merge = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

endpackage

// [hw/pic_prio_enc.sv]
// Fixed-priority encoder: lowest level index wins
`timescale 1ns/1ps
module pic_prio_enc #(
  parameter int WIDTH = 16,
  parameter int LW    = 4
) (
  input  wire logic [WIDTH-1:0] req_mask,
  output logic                  found,
  output logic [LW-1:0]         level
);

  // ---------------------------------------------------------------------------
  // Search from the lowest priority up so the highest one is left standing
  // ---------------------------------------------------------------------------
  always_comb begin
    found = 1'b0;
    level = '0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (req_mask[i]) begin
        found = 1'b1;
        level = LW'(i);
      end
    end
  end

endmodule

// [hw/pic_take_seq.sv]
// Acceptance sequencer: holds the CPU for a fixed number of cycles
`timescale 1ns/1ps
module pic_take_seq #(
  parameter int CYCLES = 8
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  typedef enum logic {PIC_TS_IDLE, PIC_TS_RUN} pic_ts_e;

  localparam int CW = $clog2(CYCLES + 1);

  pic_ts_e       state;
  logic [CW-1:0] count;
  wire           last = (count == CW'(1));

  // ---------------------------------------------------------------------------
  // Busy spans exactly CYCLES cycles, done pulses in the cycle after
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= PIC_TS_IDLE;
      count <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        PIC_TS_IDLE: begin
          if (start) begin
            state <= PIC_TS_RUN;
            count <= CW'(CYCLES);
            busy  <= 1'b1;
          end
        end
        PIC_TS_RUN: begin
          count <= count - CW'(1);
          if (last) begin
            state <= PIC_TS_IDLE;
            busy  <= 1'b0;
            done  <= 1'b1;
          end
        end
      endcase
    end
  end

endmodule

// [hw/pic_top.sv]
// Fixed-priority interrupt controller with Wishbone register access
//
// Operation
// - Fifteen sources, two pseudo non-maskable, rest maskable.
// - Each latched source sets its pending latch.
// - Accepted source's latch clears right after acceptance.
// - Reset forces all pending latches to zero.
// - Highest fixed priority wins; level 1 highest.
// - Vector per level, FFFC downward by two.
// - Software clears latches singly, never sets them.
// - Pending register reads show live latch state.
// - Pseudo non-maskable sources ignore all enables.
// - Pseudo non-maskable services never nest.
// - Enable register readable and writable except bits 1 to 3, which read zero.
// - Master flag zero blocks all maskable sources.
// - Any acceptance clears the master flag.
// - Maskable return sets master flag; pending served next.
// - Pseudo return restores master flag only if set before.
// - Master flag is enable bit 0, resets zero.
// - Enable instruction sets, disable instruction clears master.
// - Per-source flags gate levels 4 to 15; ext zero by pin.
// - Acceptance sequence lasts eight machine cycles.
// - Requests sampled in each instruction's final cycle.
// - Ext zero pin disabled means its latch never sets.
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module pic_top #(
  parameter int ACCEPT_LEN = pic_pkg::ACCEPT_CYCLES
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [7:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic [31:0]                     wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic [15:0]                src_req,
  input  wire logic                       sw_trap_req,
  input  wire logic                       cpu_instr_last,
  input  wire logic                       cpu_ret_mask,
  input  wire logic                       cpu_ret_pnmi,
  input  wire logic                       cpu_irq_on,
  input  wire logic                       cpu_irq_off,
  output logic                            irq_pending,
  output logic [15:0]                     irq_vector,
  output logic                            take_busy,
  output logic                            take_done,
  output logic [15:0]                     take_vector,
  output logic [pic_pkg::LVL_W-1:0]       take_level
);

  import pic_pkg::*;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [15:0] enable_reg;
  logic [15:0] pending_latch;
  logic [15:0] control_reg;
  logic        nmi_active;
  logic        saved_master;

  // ---------------------------------------------------------------------------
  // Wishbone decode
  // ---------------------------------------------------------------------------
  // A new request is taken only while ack is low, so each access acks once
  wire        wb_hit      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wb_wr       = wb_hit & wb_we_i;
  wire        hit_enable  = (wb_adr_i[7:2] == ADR_ENABLE[7:2]);
  wire        hit_pending = (wb_adr_i[7:2] == ADR_PENDING[7:2]);
  wire        hit_control = (wb_adr_i[7:2] == ADR_CONTROL[7:2]);
  wire        wr_enable   = wb_wr & hit_enable;
  wire        wr_pending  = wb_wr & hit_pending;
  wire        wr_control  = wb_wr & hit_control;
  wire [15:0] wdata       = wb_dat_i[15:0];
  wire [1:0]  wsel        = wb_sel_i[1:0];

  // Read mux; unmapped words read as zero and still ack
  wire [15:0] rdata = hit_enable  ? enable_reg :
                      hit_pending ? pending_latch :
                      hit_control ? control_reg :
                      16'h0000;

  // ---------------------------------------------------------------------------
  // Master flag as the current instruction leaves it
  // ---------------------------------------------------------------------------
  // Returns finish in the sampled cycle, so their flag effect is seen at once
  wire master_flag = enable_reg[MASTER_BIT];
  wire pin_en      = control_reg[PIN_EN_BIT];
  wire master_view = cpu_irq_off ? 1'b0 :
                     (cpu_irq_on | cpu_ret_mask) ? 1'b1 :
                     cpu_ret_pnmi ? saved_master :
                     master_flag;
  wire nmi_view    = nmi_active & ~cpu_ret_pnmi;

  // ---------------------------------------------------------------------------
  // Eligibility of each level
  // ---------------------------------------------------------------------------
  // Pseudo non-maskable levels bypass every enable but never nest
  wire [15:0] eligible;
  assign eligible[0]             = 1'b0;
  assign eligible[LVL_SW]        = sw_trap_req & ~nmi_view;
  assign eligible[LVL_WDT]       = pending_latch[LVL_WDT] & ~nmi_view;
  assign eligible[LVL_EXT0]      = pending_latch[LVL_EXT0] & master_view & pin_en;
  assign eligible[15:LVL_MASK0]  = pending_latch[15:LVL_MASK0] & enable_reg[15:LVL_MASK0]
                                   & {12{master_view}};

  // ---------------------------------------------------------------------------
  // Priority selection
  // ---------------------------------------------------------------------------
  logic              best_found;
  logic [LVL_W-1:0]  best_level;

  pic_prio_enc #(
    .WIDTH (NUM_LEVELS),
    .LW    (LVL_W)
  ) u_enc (
    .req_mask (eligible),
    .found    (best_found),
    .level    (best_level)
  );

  // Acceptance happens only at an instruction boundary and not mid-sequence
  wire accept   = cpu_instr_last & best_found & ~take_busy;
  wire take_nmi = (best_level == LVL_W'(LVL_SW)) | (best_level == LVL_W'(LVL_WDT));

  // ---------------------------------------------------------------------------
  // Acceptance sequencer
  // ---------------------------------------------------------------------------
  pic_take_seq #(
    .CYCLES (ACCEPT_LEN)
  ) u_seq (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .start   (accept),
    .busy    (take_busy),
    .done    (take_done)
  );

  // ---------------------------------------------------------------------------
  // Pending latch next value
  // ---------------------------------------------------------------------------
  // Ext zero is masked at the set side, so a disabled pin leaves no trace
  wire [15:0] set_vec  = src_req & LATCH_MASK
                         & ~(pin_en ? 16'h0000 : pic_onehot(LVL_W'(LVL_EXT0)));
  // Only zeros in a selected lane clear; ones and unselected lanes keep state
  wire [15:0] lane_msk = {{8{wsel[1]}}, {8{wsel[0]}}};
  wire [15:0] clr_bus  = wr_pending ? (~wdata & lane_msk) : 16'h0000;
  wire [15:0] clr_take = accept ? pic_onehot(best_level) : 16'h0000;
  // A request in the same cycle as a clear survives: the set wins
  wire [15:0] next_pending = ((pending_latch & ~(clr_bus | clr_take)) | set_vec)
                             & LATCH_MASK;

  // ---------------------------------------------------------------------------
  // Enable register next value
  // ---------------------------------------------------------------------------
  wire [15:0] en_written  = pic_merge(enable_reg, wdata, wsel) & ENABLE_MASK;
  wire [15:0] en_instr    = {enable_reg[15:1], master_view};
  wire [15:0] en_base     = wr_enable ? en_written : en_instr;
  // Acceptance overrides any other change of the master flag
  wire [15:0] next_enable = accept ? {en_base[15:1], 1'b0} : en_base;

  wire [15:0] next_control = wr_control ? (pic_merge(control_reg, wdata, wsel) & CONTROL_MASK)
                                        : control_reg;

  // ---------------------------------------------------------------------------
  // Pseudo non-maskable service tracking
  // ---------------------------------------------------------------------------
  // A clear of the master flag inside the service is remembered so the
  // pseudo return does not undo it
  wire svc_clear  = nmi_active & (cpu_irq_off | (wr_enable & wsel[0] & ~wdata[MASTER_BIT]));
  wire next_nmi   = (accept & take_nmi) ? 1'b1 : (cpu_ret_pnmi ? 1'b0 : nmi_active);
  wire next_saved = (accept & take_nmi) ? master_view :
                    svc_clear ? 1'b0 : saved_master;

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg    <= ENABLE_RESET;
      pending_latch <= PENDING_RESET;
      control_reg   <= CONTROL_RESET;
      nmi_active    <= 1'b0;
      saved_master  <= 1'b0;
    end else begin
      enable_reg    <= next_enable;
      pending_latch <= next_pending;
      control_reg   <= next_control;
      nmi_active    <= next_nmi;
      saved_master  <= next_saved;
    end
  end

  // ---------------------------------------------------------------------------
  // CPU-facing outputs
  // ---------------------------------------------------------------------------
  // Request and vector follow the eligible set every cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pending <= 1'b0;
      irq_vector  <= VEC_BASE;
      take_vector <= VEC_BASE;
      take_level  <= '0;
    end else begin
      irq_pending <= best_found;
      irq_vector  <= pic_vector(best_level);
      if (accept) begin
        take_vector <= pic_vector(best_level);
        take_level  <= best_level;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Wishbone answer
  // ---------------------------------------------------------------------------
  // Registered ack costs a cycle but keeps every output off combinational paths
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit) begin
        wb_dat_o <= {16'h0000, rdata};
      end
    end
  end

endmodule

// [test/pic_props.sv]
// Concurrent checks on the interrupt controller ports
`timescale 1ns/1ps
module pic_props #(
  parameter int ACCEPT_LEN = 8
) (
  input wire logic                       sys_clk,
  input wire logic                       rst_n,
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_ack_o,
  input wire logic                       cpu_instr_last,
  input wire logic                       irq_pending,
  input wire logic [15:0]                irq_vector,
  input wire logic                       take_busy,
  input wire logic                       take_done,
  input wire logic [15:0]                take_vector,
  input wire logic [pic_pkg::LVL_W-1:0]  take_level
);
  import pic_pkg::*;
  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------------------
  // Acceptance sequence
  // ---------------------------------------------------------------------------
  // Repeat count is written out: it matches the default sequence length only
  sequence s_busy_run;
    take_busy [*8] ##1 (!take_busy && take_done);
  endsequence
  chk_busy_len: assert property ($rose(take_busy) |-> s_busy_run)
    else $error("acceptance length wrong");
  chk_take_start: assert property ($rose(take_busy) |-> $past(cpu_instr_last))
    else $error("acceptance outside an instruction end");
  chk_take_vec: assert property ($rose(take_busy) |-> take_level != 4'h0 &&
    take_vector == 16'hFFFE - {11'h000, take_level, 1'b0})
    else $error("accepted vector and level disagree");
  chk_vec_hold: assert property (take_busy && $past(take_busy) |-> $stable(take_vector))
    else $error("accepted vector moved in sequence");
  chk_done_pulse: assert property (take_done |-> !take_busy ##1 !take_done)
    else $error("done not a single pulse");
  // ---------------------------------------------------------------------------
  // Request presentation and bus
  // ---------------------------------------------------------------------------
  chk_idle_vec: assert property (!irq_pending |-> irq_vector == 16'hFFFE)
    else $error("vector not parked when idle");
  chk_vec_range: assert property (irq_pending |-> irq_vector inside {[16'hFFE0:16'hFFFC]} && !irq_vector[0])
    else $error("presented vector out of table");
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus access not answered");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule
bind pic_top pic_props #(.ACCEPT_LEN(ACCEPT_LEN)) u_props (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cpu_instr_last(cpu_instr_last), .irq_pending(irq_pending),
  .irq_vector(irq_vector), .take_busy(take_busy), .take_done(take_done), .take_vector(take_vector),
  .take_level(take_level));

// [test/pic_cpu_model.sv]
// Behavioural CPU core: ends instructions and carries return and flag opcodes
`timescale 1ns/1ps
module pic_cpu_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       take_busy,
  input  wire logic [2:0] op,
  input  wire logic [3:0] ilen,
  output logic            instr_last,
  output logic            ret_mask,
  output logic            ret_pnmi,
  output logic            irq_on,
  output logic            irq_off,
  output logic            trap
);
  logic [3:0] cnt;
  // ---------------------------------------------------------------------------
  // Instruction timing
  // ---------------------------------------------------------------------------
  // Core stalls during acceptance, so no instruction end is ever offered then
  assign instr_last = rst_n && !take_busy && (cnt >= ilen);
  // Opcode strobes ride only on the final cycle of their instruction
  assign ret_mask = instr_last && (op == 3'h1);
  assign ret_pnmi = instr_last && (op == 3'h2);
  assign irq_on   = instr_last && (op == 3'h3);
  assign irq_off  = instr_last && (op == 3'h4);
  assign trap     = instr_last && (op == 3'h5);
  // Length counter; a long ilen models a slow core
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
    end else if (instr_last || take_busy) begin
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// [test/test_prioritized_interrupt_controller.sv]
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
module test_prioritized_interrupt_controller;
  import pic_pkg::*;
  logic sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_pending, take_busy, take_done;
  logic sw_trap_req, cpu_instr_last, cpu_ret_mask, cpu_ret_pnmi, cpu_irq_on, cpu_irq_off;
  logic [7:0]       wb_adr_i;
  logic [3:0]       wb_sel_i, ilen;
  logic [LVL_W-1:0] take_level;
  logic [31:0]      wb_dat_i, wb_dat_o, rd;
  logic [15:0]      src_req, irq_vector, take_vector;
  logic [2:0]       op;
  int err_total = 0, n_compared = 0, cycles = 0;
  pic_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .src_req(src_req), .sw_trap_req(sw_trap_req), .cpu_instr_last(cpu_instr_last),
    .cpu_ret_mask(cpu_ret_mask), .cpu_ret_pnmi(cpu_ret_pnmi), .cpu_irq_on(cpu_irq_on), .cpu_irq_off(cpu_irq_off),
    .irq_pending(irq_pending), .irq_vector(irq_vector),
    .take_busy(take_busy), .take_done(take_done), .take_vector(take_vector), .take_level(take_level));
  pic_cpu_model u_cpu (.sys_clk(sys_clk), .rst_n(rst_n), .take_busy(take_busy), .op(op), .ilen(ilen),
    .instr_last(cpu_instr_last), .ret_mask(cpu_ret_mask), .ret_pnmi(cpu_ret_pnmi), .irq_on(cpu_irq_on),
    .irq_off(cpu_irq_off), .trap(sw_trap_req));
  // ---------------------------------------------------------------------------
  // Clock, hang guard and helpers
  // ---------------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Whole run needs well under a thousand cycles; the ceiling leaves slack
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Single classic cycle; signals held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_sel_i <= 4'h3;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [15:0] e);
    wb(1'b0, a, 16'h0000);
    chk(n, {16'h0000, e}, rd);
  endtask
  task automatic pulse(input logic [15:0] s);
    src_req <= s;
    @(posedge sys_clk);
    src_req <= 16'h0000;
  endtask
  // Opcode held until the core ends the instruction that carries it
  task automatic cpu(input logic [2:0] o);
    op <= o;
    do @(posedge sys_clk); while (cpu_instr_last !== 1'b1);
    op <= 3'h0;
  endtask
  task automatic take(input logic [15:0] v);
    int k = 0;
    while (take_busy !== 1'b1 && k < 60) begin
      @(posedge sys_clk);
      k++;
    end
    chk("take", {11'h000, LVL_W'((VEC_BASE - v) >> 1), 1'b1, v}, {11'h000, take_level, take_busy, take_vector});
    while (take_busy === 1'b1) @(posedge sys_clk);
    chk("take_done", 32'h1, {31'h0, take_done});
    @(posedge sys_clk);
  endtask
  task automatic noacc(input int n);
    logic seen = 1'b0;
    repeat (n) begin
      @(posedge sys_clk);
      if (take_busy === 1'b1) seen = 1'b1;
    end
    chk("no_take", 32'h0, {31'h0, seen});
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_regs();
    rchk("enable_rst", ADR_ENABLE, 16'h0000);
    rchk("pending_rst", ADR_PENDING, 16'h0000);
    wb(1'b1, ADR_ENABLE, 16'hFFFF);
    rchk("enable_rw", ADR_ENABLE, 16'hFFF1);
    wb(1'b1, ADR_ENABLE, 16'h0000);
    wb(1'b1, 8'h10, 16'hFFFF);
    rchk("unmapped", 8'h10, 16'h0000);
    wb(1'b1, ADR_PENDING, 16'hFFFF);
    rchk("no_set", ADR_PENDING, 16'h0000);
    $display("done t_regs");
  endtask
  task automatic t_latch();
    pulse(16'h8032);
    rchk("latch_set", ADR_PENDING, 16'h8030);
    wb(1'b1, ADR_PENDING, 16'hFFEF);
    rchk("latch_clr", ADR_PENDING, 16'h8020);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rchk("latch_rst", ADR_PENDING, 16'h0000);
    $display("done t_latch");
  endtask
  task automatic t_prio();
    wb(1'b1, ADR_ENABLE, 16'hFFF0);
    pulse(16'h8240);
    noacc(20);
    chk("irq_off", 32'h0000_FFFE, {15'h0000, irq_pending, irq_vector});
    cpu(3'h3);
    take(16'hFFF2);
    rchk("flag_off", ADR_ENABLE, 16'hFFF0);
    rchk("taken_clr", ADR_PENDING, 16'h8200);
    cpu(3'h1);
    take(16'hFFEC);
    cpu(3'h1);
    take(16'hFFE0);
    cpu(3'h1);
    cpu(3'h4);
    rchk("flag_di", ADR_ENABLE, 16'hFFF0);
    wb(1'b1, ADR_ENABLE, 16'h0001);
    pulse(16'h0010);
    noacc(20);
    rchk("held", ADR_PENDING, 16'h0010);
    wb(1'b1, ADR_PENDING, 16'h0004);
    rchk("store_clr", ADR_PENDING, 16'h0000);
    $display("done t_prio");
  endtask
  // Master flag is set on entry, so the first pseudo return sets it again
  task automatic t_pnmi();
    ilen <= 4'h6;
    pulse(16'h0004);
    @(posedge sys_clk);
    @(posedge sys_clk);
    chk("irq_wdt", {15'h0000, 1'b1, 16'hFFFA}, {15'h0000, irq_pending, irq_vector});
    take(16'hFFFA);
    cpu(3'h5);
    noacc(20);
    cpu(3'h2);
    rchk("pseudo_nmi_return_instr_set", ADR_ENABLE, 16'h0001);
    cpu(3'h5);
    take(16'hFFFC);
    cpu(3'h4);
    pulse(16'h0004);
    noacc(20);
    cpu(3'h2);
    take(16'hFFFA);
    cpu(3'h2);
    rchk("pseudo_nmi_return_instr_keep", ADR_ENABLE, 16'h0000);
    ilen <= 4'h2;
    $display("done t_pnmi");
  endtask
  task automatic t_ext0();
    wb(1'b1, ADR_CONTROL, 16'h0000);
    pulse(16'h0008);
    rchk("pin_off", ADR_PENDING, 16'h0000);
    wb(1'b1, ADR_CONTROL, 16'h0001);
    pulse(16'h0008);
    rchk("pin_on", ADR_PENDING, 16'h0008);
    cpu(3'h3);
    take(16'hFFF8);
    cpu(3'h1);
    $display("done t_ext0");
  endtask
  initial begin
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h3;
    wb_dat_i = 32'h0;
    src_req = 16'h0000;
    op = 3'h0;
    ilen = 4'h2;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_latch();
    t_prio();
    t_pnmi();
    t_ext0();
    end_of_test();
  end
endmodule
